// *** hw/qm_map.svh ***
`ifndef QM_MAP_SVH
`define QM_MAP_SVH

// ----------
// Buffer geometry and descriptor layout
// ----------
`define QB_AW 11
`define QB_DEPTH 2048
`define HDR_WORDS 11'h002
`define CNT_WORD 11'h001
`define PTR_ONE 11'h001
`define CTL_IRQ_BIT 15
`define TAG_MSB 5
`define CNT_MSB 10
`define TXR_DONE 15

// ----------
// Frame length classes and checksum
// ----------
`define MAX_DATA 11'h77C
`define MAX_FRAME 11'h5EE
`define MAX_LEN_FIELD 16'h05DC
`define MIN_FRAME 11'h040
`define ADDR_BYTES 11'h006
`define LT_HI_BYTE 11'h00C
`define LT_LO_BYTE 11'h00D
`define FCS_BYTES 11'h004
`define FCS_LAST 2'h3
`define CRC_POLY 32'hEDB8_8320
`define CRC_INIT 32'hFFFF_FFFF

// ----------
// Controller register map
// ----------
`define REG_CTRL 8'h00
`define REG_TX_DATA 8'h04
`define REG_TX_COMMIT 8'h08
`define REG_TX_STAT 8'h0C
`define REG_RX_STAT 8'h10
`define REG_RX_DATA 8'h14
`define REG_RX_RELEASE 8'h18
`define REG_EVENT 8'h1C
`define CTRL_CRC_GEN 0
`define CTRL_STRIP 1
`define CTRL_PASS_BAD 2
`define APB_WAIT 2'h2

`endif

// *** hw/qm_pkg.sv ***
package qm_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_CTRL = 3'b001,
        TX_CNT = 3'b010,
        TX_DATA = 3'b011,
        TX_FCS = 3'b100,
        TX_DONE = 3'b101
    } tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_STAT = 2'b10,
        RX_CNT = 2'b11
    } rx_state_type;

endpackage

// *** hw/qm_if.sv ***
`timescale 1ns/1ps

interface qm_if;
    logic tx_wr;
    logic [15:0] tx_wdata;
    logic tx_commit;
    logic rx_rd;
    logic rx_release;
    logic crc_gen_en;
    logic crc_strip_en;
    logic pass_bad_en;
    logic [10:0] tx_free;
    logic [15:0] tx_result_reg;
    logic tx_done_irq_request;
    logic [15:0] rx_result_reg;
    logic [15:0] rx_length_field;
    logic [15:0] rx_rdata;

    modport dev (
        input tx_wr, tx_wdata, tx_commit, rx_rd, rx_release,
        input crc_gen_en, crc_strip_en, pass_bad_en,
        output tx_free, tx_result_reg, tx_done_irq_request,
        output rx_result_reg, rx_length_field, rx_rdata
    );

    modport host (
        output tx_wr, tx_wdata, tx_commit, rx_rd, rx_release,
        output crc_gen_en, crc_strip_en, pass_bad_en,
        input tx_free, tx_result_reg, tx_done_irq_request,
        input rx_result_reg, rx_length_field, rx_rdata
    );
endinterface

// *** hw/queue_manager.sv ***
`timescale 1ns/1ps
`include "qm_map.svh"

// Overview of operation
// - Separate 4KB transmit and receive frame buffers.
// - Host frame: control, count, then data.
// - Control bit 15 requests completion interrupt.
// - Frame tag copied into transmit status.
// - Host writes exact nonzero byte count.
// - Byte count sizes space and send length.
// - Descriptor words word aligned, two per frame.
// - Checksum appended only when generation enabled.
// - Addresses sent as supplied, none inserted.
// - Length/type word is plain payload.
// - Transmit status follows frame now sending.
// - Stored frame: status, count, data.
// - Strip received checksum when stripping enabled.
// - Valid bit only for complete frames.
// - Broadcast, multicast, unicast class bits.
// - Type bit when length field exceeds 1500.
// - Oversize flagged, passed only if allowed.
// - Runt flagged, passed only if allowed.
// - Checksum errors flagged, else discarded.
// - Received byte count in bits 10-0.
// - Status describes frame at buffer head.
module queue_manager
    import qm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    qm_if.dev link,
    output logic mac_tx_valid,
    output logic [7:0] mac_tx_data,
    output logic mac_tx_last,
    input wire logic mac_tx_ready,
    input wire logic mac_rx_valid,
    input wire logic [7:0] mac_rx_data,
    input wire logic mac_rx_last,
    input wire logic mac_rx_crc_bad,
    input wire logic mac_rx_collision
);

    // ----------
    // Shared helpers
    // ----------
    function automatic logic [`QB_AW-1:0] next_base(input logic [`QB_AW-1:0] base,
                                                   input logic [10:0] cnt);
        logic [11:0] words;
        words = ({1'b0, cnt} + 12'h001) >> 1;
        next_base = base + `HDR_WORDS + words[`QB_AW-1:0];
    endfunction

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        crc_byte = r;
    endfunction

    logic [15:0] tx_mem [0:`QB_DEPTH-1];
    logic [15:0] rx_mem [0:`QB_DEPTH-1];

    // ----------
    // Transmit side
    // ----------
    tx_state_type tx_state_r;
    logic [10:0] tx_wr_ptr_r, tx_commit_r, tx_tail_r, tx_cnt_r, tx_idx_r;
    logic [15:0] tx_ctrl_r;
    logic [31:0] tx_crc_r;
    logic [1:0] tx_fcs_r;
    logic [15:0] tx_word;
    logic [7:0] tx_byte;
    logic [31:0] fcs_word;
    logic tx_take, tx_full, tx_end_data;

    assign tx_take = !mac_tx_valid || mac_tx_ready;
    assign tx_full = (tx_wr_ptr_r + `PTR_ONE) == tx_tail_r;
    assign tx_word = tx_mem[tx_tail_r + `HDR_WORDS + {1'b0, tx_idx_r[10:1]}];
    // Every byte leaves as stored, so addresses and length/type pass untouched.
    assign tx_byte = tx_idx_r[0] ? tx_word[15:8] : tx_word[7:0];
    assign fcs_word = ~tx_crc_r;
    assign tx_end_data = tx_idx_r == tx_cnt_r - `PTR_ONE;

    always_ff @(posedge pclk) begin
        if (link.tx_wr && !tx_full) begin
            tx_mem[tx_wr_ptr_r] <= link.tx_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_ptr_r <= 11'h000;
            tx_commit_r <= 11'h000;
        end else begin
            if (link.tx_wr && !tx_full) begin
                tx_wr_ptr_r <= tx_wr_ptr_r + `PTR_ONE;
            end
            if (link.tx_commit) begin
                tx_commit_r <= tx_wr_ptr_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= TX_IDLE;
            tx_tail_r <= 11'h000;
            tx_cnt_r <= 11'h000;
            tx_idx_r <= 11'h000;
            tx_ctrl_r <= 16'h0000;
            tx_crc_r <= `CRC_INIT;
            tx_fcs_r <= 2'h0;
            link.tx_result_reg <= 16'h0000;
            link.tx_done_irq_request <= 1'b0;
        end else begin
            link.tx_done_irq_request <= 1'b0;
            unique case (tx_state_r)
                TX_IDLE: begin
                    if (tx_commit_r != tx_tail_r) begin
                        tx_state_r <= TX_CTRL;
                    end
                end
                TX_CTRL: begin
                    tx_ctrl_r <= tx_mem[tx_tail_r];
                    // Status now describes this frame, not the newest queued one.
                    link.tx_result_reg <= {10'h000, tx_mem[tx_tail_r][`TAG_MSB:0]};
                    tx_state_r <= TX_CNT;
                end
                TX_CNT: begin
                    tx_cnt_r <= tx_mem[tx_tail_r + `CNT_WORD][`CNT_MSB:0];
                    tx_idx_r <= 11'h000;
                    tx_crc_r <= `CRC_INIT;
                    tx_state_r <= TX_DATA;
                end
                TX_DATA: begin
                    if (tx_take) begin
                        tx_crc_r <= crc_byte(tx_crc_r, tx_byte);
                        tx_idx_r <= tx_idx_r + `PTR_ONE;
                        tx_fcs_r <= 2'h0;
                        if (tx_end_data) begin
                            tx_state_r <= link.crc_gen_en ? TX_FCS : TX_DONE;
                        end
                    end
                end
                TX_FCS: begin
                    if (tx_take) begin
                        tx_fcs_r <= tx_fcs_r + 2'h1;
                        if (tx_fcs_r == `FCS_LAST) begin
                            tx_state_r <= TX_DONE;
                        end
                    end
                end
                TX_DONE: begin
                    if (tx_take) begin
                        tx_tail_r <= next_base(tx_tail_r, tx_cnt_r);
                        link.tx_result_reg[`TXR_DONE] <= 1'b1;
                        link.tx_done_irq_request <= tx_ctrl_r[`CTL_IRQ_BIT];
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_tx_valid <= 1'b0;
            mac_tx_data <= 8'h00;
            mac_tx_last <= 1'b0;
        end else if (tx_take) begin
            mac_tx_valid <= (tx_state_r == TX_DATA) || (tx_state_r == TX_FCS);
            mac_tx_data <= (tx_state_r == TX_FCS) ? fcs_word[{tx_fcs_r, 3'b000} +: 8] : tx_byte;
            mac_tx_last <= ((tx_state_r == TX_DATA) && tx_end_data && !link.crc_gen_en) ||
                           ((tx_state_r == TX_FCS) && (tx_fcs_r == `FCS_LAST));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.tx_free <= 11'h7FF;
        end else begin
            link.tx_free <= 11'h7FF - (tx_wr_ptr_r - tx_tail_r);
        end
    end

    // ----------
    // Receive side
    // ----------
    rx_state_type rx_state_r;
    logic [10:0] rx_base_r, rx_head_r, rx_rd_r, rx_n_r, rx_frames_r, rx_len;
    logic [7:0] rx_lo_r;
    logic [15:0] rx_lt_r, rx_status;
    logic rx_bcast_r, rx_mcast_r, rx_long_r, rx_ovf_r, rx_crc_r, rx_coll_r;
    logic rx_byte_in, rx_room, rx_store, rx_runt, rx_keep;
    logic [10:0] rx_addr, rx_head_next;

    assign rx_byte_in = mac_rx_valid && ((rx_state_r == RX_IDLE) || (rx_state_r == RX_DATA));
    assign rx_addr = rx_base_r + `HDR_WORDS + {1'b0, rx_n_r[10:1]};
    // One word is kept free so that a full buffer never looks empty.
    assign rx_room = (rx_addr + `PTR_ONE) != rx_head_r;
    assign rx_store = rx_room && !rx_ovf_r && (rx_n_r < `MAX_DATA);
    assign rx_runt = rx_coll_r || (rx_n_r < `MIN_FRAME);
    assign rx_keep = !rx_ovf_r &&
                     (link.pass_bad_en || !(rx_crc_r || rx_runt || rx_long_r));
    assign rx_len = (link.crc_strip_en && (rx_n_r >= `FCS_BYTES)) ?
                    rx_n_r - `FCS_BYTES : rx_n_r;
    assign rx_status = {1'b1, 7'h00, rx_bcast_r, rx_mcast_r, !rx_mcast_r, 1'b0,
                        rx_lt_r > `MAX_LEN_FIELD, rx_long_r, rx_runt, rx_crc_r};
    assign rx_head_next = next_base(rx_head_r, rx_mem[rx_head_r + `CNT_WORD][`CNT_MSB:0]);

    always_ff @(posedge pclk) begin
        if (rx_byte_in && rx_store && rx_n_r[0]) begin
            rx_mem[rx_addr] <= {mac_rx_data, rx_lo_r};
        end else if (rx_byte_in && rx_store && mac_rx_last) begin
            rx_mem[rx_addr] <= {8'h00, mac_rx_data};
        end else if (rx_state_r == RX_STAT) begin
            rx_mem[rx_base_r] <= rx_status;
        end else if (rx_state_r == RX_CNT) begin
            rx_mem[rx_base_r + `CNT_WORD] <= {5'h00, rx_len};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
            rx_base_r <= 11'h000;
            rx_n_r <= 11'h000;
            rx_lo_r <= 8'h00;
            rx_lt_r <= 16'h0000;
            rx_bcast_r <= 1'b1;
            rx_mcast_r <= 1'b0;
            rx_long_r <= 1'b0;
            rx_ovf_r <= 1'b0;
            rx_crc_r <= 1'b0;
            rx_coll_r <= 1'b0;
        end else begin
            unique case (rx_state_r)
                RX_IDLE, RX_DATA: begin
                    if (rx_byte_in) begin
                        rx_state_r <= mac_rx_last ? RX_STAT : RX_DATA;
                        rx_lo_r <= mac_rx_data;
                        if (rx_n_r < `MAX_DATA) begin
                            rx_n_r <= rx_n_r + `PTR_ONE;
                        end
                        // Oversize frames are only marked; storage is not cut short here.
                        if (rx_n_r >= `MAX_FRAME) begin
                            rx_long_r <= 1'b1;
                        end
                        if ((rx_n_r < `ADDR_BYTES) && (mac_rx_data != 8'hFF)) begin
                            rx_bcast_r <= 1'b0;
                        end
                        if (rx_n_r == 11'h000) begin
                            rx_mcast_r <= mac_rx_data[0];
                        end
                        if (rx_n_r == `LT_HI_BYTE) begin
                            rx_lt_r[15:8] <= mac_rx_data;
                        end
                        if (rx_n_r == `LT_LO_BYTE) begin
                            rx_lt_r[7:0] <= mac_rx_data;
                        end
                        if (!rx_room) begin
                            rx_ovf_r <= 1'b1;
                        end
                        if (mac_rx_last) begin
                            rx_crc_r <= mac_rx_crc_bad;
                            rx_coll_r <= mac_rx_collision;
                        end
                    end
                end
                RX_STAT: begin
                    rx_state_r <= rx_keep ? RX_CNT : RX_IDLE;
                end
                RX_CNT: begin
                    rx_base_r <= next_base(rx_base_r, rx_len);
                    rx_state_r <= RX_IDLE;
                end
            endcase
            // A kept frame still needs its byte count in the count cycle.
            if ((rx_state_r == RX_STAT && !rx_keep) || rx_state_r == RX_CNT) begin
                rx_n_r <= 11'h000;
                rx_lt_r <= 16'h0000;
                rx_bcast_r <= 1'b1;
                rx_mcast_r <= 1'b0;
                rx_long_r <= 1'b0;
                rx_ovf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_frames_r <= 11'h000;
            rx_head_r <= 11'h000;
            rx_rd_r <= 11'h000;
        end else begin
            if ((rx_state_r == RX_CNT) && !(link.rx_release && rx_frames_r != 11'h000)) begin
                rx_frames_r <= rx_frames_r + `PTR_ONE;
            end else if ((rx_state_r != RX_CNT) && link.rx_release && rx_frames_r != 11'h000) begin
                rx_frames_r <= rx_frames_r - `PTR_ONE;
            end
            if (link.rx_release && rx_frames_r != 11'h000) begin
                rx_head_r <= rx_head_next;
                rx_rd_r <= rx_head_next;
            end else if (link.rx_rd) begin
                rx_rd_r <= rx_rd_r + `PTR_ONE;
            end
        end
    end

    // Only committed frames show; a frame still arriving leaves the valid bit clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.rx_result_reg <= 16'h0000;
            link.rx_length_field <= 16'h0000;
            link.rx_rdata <= 16'h0000;
        end else begin
            link.rx_result_reg <= (rx_frames_r != 11'h000) ? rx_mem[rx_head_r] : 16'h0000;
            link.rx_length_field <= (rx_frames_r != 11'h000) ?
                                    rx_mem[rx_head_r + `CNT_WORD] : 16'h0000;
            link.rx_rdata <= rx_mem[rx_rd_r];
        end
    end

endmodule // queue_manager

// *** hw/host_controller.sv ***
`timescale 1ns/1ps
`include "qm_map.svh"

module host_controller
    import qm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    qm_if.host link
);

    // ----------
    // Bus slave
    // ----------
    logic [1:0] wait_r;
    logic tx_done_seen_r;
    logic done, wr_done, hit;
    logic [31:0] rd_mux;

    assign done = psel && penable && pready;
    assign wr_done = done && pwrite;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `REG_CTRL: rd_mux = {29'h0000_0000, link.pass_bad_en, link.crc_strip_en,
                                 link.crc_gen_en};
            `REG_TX_DATA, `REG_TX_COMMIT, `REG_RX_RELEASE: rd_mux = 32'h0000_0000;
            `REG_TX_STAT: rd_mux = {5'h00, link.tx_free, link.tx_result_reg};
            `REG_RX_STAT: rd_mux = {link.rx_length_field, link.rx_result_reg};
            `REG_RX_DATA: rd_mux = {16'h0000, link.rx_rdata};
            `REG_EVENT: rd_mux = {31'h0000_0000, tx_done_seen_r};
            default: hit = 1'b0;
        endcase
    end

    // The extra wait cycles let the device's read word settle after a pop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 2'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                if (wait_r != `APB_WAIT) begin
                    wait_r <= wait_r + 2'h1;
                end else begin
                    wait_r <= 2'h0;
                    pready <= 1'b1;
                    pslverr <= !hit;
                    prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                end
            end
        end
    end

    // ----------
    // Orders to the queue manager
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.tx_wr <= 1'b0;
            link.tx_wdata <= 16'h0000;
            link.tx_commit <= 1'b0;
            link.rx_rd <= 1'b0;
            link.rx_release <= 1'b0;
        end else begin
            link.tx_wr <= wr_done && (paddr == `REG_TX_DATA);
            link.tx_commit <= wr_done && (paddr == `REG_TX_COMMIT);
            link.rx_rd <= done && !pwrite && (paddr == `REG_RX_DATA);
            link.rx_release <= wr_done && (paddr == `REG_RX_RELEASE);
            if (wr_done && (paddr == `REG_TX_DATA)) begin
                link.tx_wdata <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.crc_gen_en <= 1'b0;
            link.crc_strip_en <= 1'b0;
            link.pass_bad_en <= 1'b0;
        end else if (wr_done && (paddr == `REG_CTRL)) begin
            link.crc_gen_en <= pwdata[`CTRL_CRC_GEN];
            link.crc_strip_en <= pwdata[`CTRL_STRIP];
            link.pass_bad_en <= pwdata[`CTRL_PASS_BAD];
        end
    end

    // A completion arriving with the clear keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_seen_r <= 1'b0;
        end else if (link.tx_done_irq_request) begin
            tx_done_seen_r <= 1'b1;
        end else if (wr_done && (paddr == `REG_EVENT) && pwdata[0]) begin
            tx_done_seen_r <= 1'b0;
        end
    end

endmodule // host_controller

// *** dv/qm_link_assertions.sv ***
`timescale 1ns/1ps

// ----------
// Link word checks.
// ----------
module qm_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_wr,
    input wire logic [15:0] tx_result_reg,
    input wire logic tx_done_irq_request,
    input wire logic [15:0] rx_result_reg,
    input wire logic [15:0] rx_length_field
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Each push is a whole bus transfer, so three quiet cycles always follow it.
    sequence s_quiet; !tx_wr [*3]; endsequence
    property p_wr_gap; tx_wr |=> s_quiet; endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("push spacing");
    property p_irq_done; tx_done_irq_request |-> ##[0:1] tx_result_reg[15]; endproperty
    a_irq_done: assert property (p_irq_done) else $error("irq without done");
    property p_irq_pulse; tx_done_irq_request |=> !tx_done_irq_request; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    property p_tag_new; $changed(tx_result_reg[5:0]) |-> !tx_result_reg[15]; endproperty
    a_tag_new: assert property (p_tag_new) else $error("new tag marked done");
    property p_tx_fmt; tx_result_reg[14:6] == 9'h000; endproperty
    a_tx_fmt: assert property (p_tx_fmt) else $error("tx result spare bits");
    property p_rx_spare; rx_result_reg[14:8] == 7'h00 && !rx_result_reg[4]; endproperty
    a_rx_spare: assert property (p_rx_spare) else $error("rx status spare bits");
    property p_rx_len; rx_length_field <= 16'h077C; endproperty
    a_rx_len: assert property (p_rx_len) else $error("rx count word");
    property p_novalid; !rx_result_reg[15] |-> rx_result_reg == 16'h0000; endproperty
    a_novalid: assert property (p_novalid) else $error("status without frame");
    property p_bcast; rx_result_reg[7] |-> rx_result_reg[6]; endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast not multicast");
    property p_class; rx_result_reg[15] |-> rx_result_reg[6] != rx_result_reg[5]; endproperty
    a_class: assert property (p_class) else $error("address class");
endmodule // qm_link_assertions

// *** dv/tb_packet_queue_frame_manager.sv ***
`timescale 1ns/1ps

// ----------
// Bench for both link ends.
// ----------
module tb_packet_queue_frame_manager;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, mac_rx_data = 8'h00, mac_tx_data;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, err, mac_tx_valid, mac_tx_last, mac_tx_ready = 1'b0;
    logic mac_rx_valid = 1'b0, mac_rx_last = 1'b0, mac_rx_crc_bad = 1'b0;
    logic mac_rx_collision = 1'b0;
    int n_mismatch = 0, check_count = 0;
    logic [8:0] txe[$], txg[$];
    logic [7:0] rxb[$];
    qm_if qi();
    host_controller host_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link(qi));
    queue_manager queue_manager_inst (.pclk, .presetn, .link(qi), .mac_tx_valid,
        .mac_tx_data, .mac_tx_last, .mac_tx_ready, .mac_rx_valid, .mac_rx_data,
        .mac_rx_last, .mac_rx_crc_bad, .mac_rx_collision);
    qm_link_assertions qm_link_assertions_inst (.pclk, .presetn, .tx_wr(qi.tx_wr),
        .tx_result_reg(qi.tx_result_reg), .tx_done_irq_request(qi.tx_done_irq_request),
        .rx_result_reg(qi.rx_result_reg), .rx_length_field(qi.rx_length_field));
    always #12.5 pclk = ~pclk;
    // The far side stalls at random so held bytes are exercised.
    always @(posedge pclk) mac_tx_ready <= ($urandom % 4) != 0;
    always @(posedge pclk) if (mac_tx_valid && mac_tx_ready) txg.push_back({mac_tx_last, mac_tx_data});
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang;
        chk("wait_bound", 32'h0000_0000, 32'h0000_0001);
        finish_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40) hang();
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] crc32(input logic [8:0] q[$]);
        logic [31:0] c;
        c = 32'hFFFF_FFFF;
        foreach (q[i]) begin
            c = c ^ {24'h00_0000, q[i][7:0]};
            repeat (8) c = (c >> 1) ^ (c[0] ? 32'hEDB8_8320 : 32'h0000_0000);
        end
        return ~c;
    endfunction
    task automatic rx_case(input int kind, n, input logic bad, col, strip, pass);
        logic [15:0] st;
        logic [10:0] cnt;
        logic keep, mc, rn, lg, ty;
        rxb.delete();
        for (int i = 0; i < n; i++) rxb.push_back(8'($urandom));
        for (int i = 0; i < 6; i++) if (kind == 0) rxb[i] = 8'hFF;
        if (kind != 0) rxb[0] = {7'h00, kind == 1};
        rxb[12] = kind == 0 ? 8'h08 : 8'h00;
        mc = rxb[0][0];
        ty = {rxb[12], rxb[13]} > 16'h05DC;
        lg = n > 1518;
        rn = col || n < 64;
        keep = pass || !(bad || rn || lg);
        cnt = strip ? 11'(n - 4) : 11'(n);
        st = keep ? {1'b1, 7'h00, kind == 0, mc, !mc, 1'b0, ty, lg, rn, bad} : 16'h0000;
        apb(1'b1, 8'h00, {29'h0000_0000, pass, strip, 1'b0});
        foreach (rxb[i]) begin
            mac_rx_valid <= 1'b1;
            mac_rx_data <= rxb[i];
            mac_rx_last <= i == n - 1;
            mac_rx_crc_bad <= bad;
            mac_rx_collision <= col;
            @(posedge pclk);
        end
        mac_rx_valid <= 1'b0;
        mac_rx_last <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("rx_status", st, rdv[15:0]);
        if (keep) begin
            chk("rx_count", cnt, rdv[31:16]);
            apb(1'b0, 8'h14, 32'h0000_0000);
            chk("rx_word_status", st, rdv[15:0]);
            apb(1'b0, 8'h14, 32'h0000_0000);
            chk("rx_word_count", cnt, rdv[15:0]);
            for (int j = 0; j < 3; j++) begin
                apb(1'b0, 8'h14, 32'h0000_0000);
                chk("rx_word_data", {rxb[2*j+1], rxb[2*j]}, rdv[15:0]);
            end
            apb(1'b1, 8'h18, 32'h0000_0000);
            apb(1'b0, 8'h10, 32'h0000_0000);
            chk("rx_released", 32'h0000_0000, rdv[15:0]);
        end
    endtask
    initial begin
        int n, k;
        logic [15:0] w;
        logic [31:0] c;
        logic [5:0] tag;
        void'($urandom(69));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("tx_free", 11'h7FF, qi.tx_free);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, err);
        chk("unmapped_data", 32'h0000_0000, rdv);
        for (int g = 0; g < 2; g++) begin
            n = 13 + $urandom % 28;
            tag = 6'($urandom);
            txe.delete();
            txg.delete();
            apb(1'b1, 8'h00, {31'h0000_0000, g[0]});
            apb(1'b1, 8'h04, {16'h0000, g[0], 9'($urandom), tag});
            apb(1'b1, 8'h04, {16'h0000, 5'h1F, 11'(n)});
            for (int i = 0; i < n; i += 2) begin
                w = 16'($urandom);
                txe.push_back({1'b0, w[7:0]});
                if (i + 1 < n) txe.push_back({1'b0, w[15:8]});
                apb(1'b1, 8'h04, {16'h0000, w});
            end
            c = crc32(txe);
            for (int i = 0; i < 4; i++) if (g == 1) txe.push_back({1'b0, c[8*i +: 8]});
            txe[$][8] = 1'b1;
            apb(1'b1, 8'h08, 32'h0000_0000);
            k = 0;
            while (txg.size() < txe.size()) begin
                @(posedge pclk);
                k++;
                if (k > 3000) hang();
            end
            repeat (6) @(posedge pclk);
            chk("tx_len", txe.size(), txg.size());
            foreach (txe[i]) chk("tx_byte", txe[i], txg[i]);
            k = 0;
            do begin
                apb(1'b0, 8'h0C, 32'h0000_0000);
                k++;
            end while (rdv[15] !== 1'b1 && k < 20);
            if (rdv[15] !== 1'b1) hang();
            chk("tx_stat", {5'h00, 11'h7FF, 1'b1, 9'h000, tag}, rdv);
            apb(1'b0, 8'h1C, 32'h0000_0000);
            chk("tx_event", g, rdv[0]);
            apb(1'b1, 8'h1C, 32'h0000_0001);
            apb(1'b0, 8'h1C, 32'h0000_0000);
            chk("tx_event_clear", 32'h0000_0000, rdv[0]);
        end
        rx_case(0, 64, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_case(1, 72, 1'b0, 1'b0, 1'b1, 1'b0);
        rx_case(2, 60, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(2, 80, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_case(2, 64, 1'b1, 1'b0, 1'b0, 1'b0);
        rx_case(2, 66, 1'b1, 1'b0, 1'b1, 1'b1);
        rx_case(1, 1520, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(2, 1520, 1'b0, 1'b0, 1'b0, 1'b0);
        finish_test();
    end
endmodule // tb_packet_queue_frame_manager
